// file: rtl/press_fmt_pkg.sv
package press_fmt_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_WRITE_ENABLE = 8'h00;
   localparam logic [7:0] OFS_PUNIT = 8'h04;
   localparam logic [7:0] OFS_USER_FACTOR = 8'h08;
   localparam logic [7:0] OFS_USER_INVERSE = 8'h0c;
   localparam logic [7:0] OFS_TUNIT = 8'h10;
   localparam logic [7:0] OFS_TARE_STATE = 8'h14;
   localparam logic [7:0] OFS_TARE_VALUE = 8'h18;
   localparam logic [7:0] OFS_TARE_LOCK = 8'h1c;
   localparam logic [7:0] OFS_SETPOINT = 8'h20;
   localparam logic [7:0] OFS_FORMAT = 8'h24;
   localparam logic [7:0] OFS_USER_LABEL = 8'h28;
   localparam logic [7:0] OFS_ADDRESS = 8'h2c;
   localparam logic [7:0] OFS_STATUS = 8'h30;
   localparam logic [7:0] OFS_LAST_PRESSURE = 8'h34;

   // Factors are signed Q10.22, measurements signed Q16.16
   localparam int FRAC_BITS = 22;
   localparam real ONE_Q = 4194304.0;
   localparam logic [31:0] F_ONE = 32'h0040_0000;
   localparam logic [31:0] F_HPA = 32'($rtoi(68.94757 * ONE_Q + 0.5));
   localparam logic [31:0] F_BAR = 32'($rtoi(0.06894757 * ONE_Q + 0.5));
   localparam logic [31:0] F_KPA = 32'($rtoi(6.894757 * ONE_Q + 0.5));
   localparam logic [31:0] F_MPA = 32'($rtoi(0.00689476 * ONE_Q + 0.5));
   localparam logic [31:0] F_INHG = 32'($rtoi(2.036021 * ONE_Q + 0.5));
   localparam logic [31:0] F_MMHG = 32'($rtoi(51.71493 * ONE_Q + 0.5));
   localparam logic [31:0] F_MH2O = 32'($rtoi(0.7030696 * ONE_Q + 0.5));
   localparam logic [31:0] F_FAHR_SCALE = 32'($rtoi(1.8 * ONE_Q + 0.5));
   localparam logic [31:0] FAHR_OFFSET = 32'h0020_0000;
   localparam logic [31:0] FULL_SCALE_PSI = 32'h001e_0000;

   localparam logic [3:0] UNIT_USER = 4'h0;
   localparam logic [3:0] UNIT_PSI = 4'h1;
   localparam logic [3:0] UNIT_MAX = 4'h8;
   localparam logic [1:0] TARE_OFF = 2'h0;
   localparam logic [1:0] TARE_REQ = 2'h1;
   localparam logic [1:0] TARE_ACTIVE = 2'h2;
   localparam logic [31:0] WE_KEY = 32'h0000_0001;
   localparam logic [31:0] USER_LABEL_RESET = 32'h7265_7375;
   localparam logic [31:0] ADDRESS_RESET = 32'h3130_3030;
   localparam logic [7:0] CHAR_MIN = 8'h20;
   localparam logic [7:0] CHAR_MAX = 8'h7f;

   // Fixed-point to decimal: value * 10^5 >> 16, then 10 BCD digits
   localparam logic [16:0] DEC_SCALE = 17'h186a0;
   localparam int FIELD_CHARS = 11;
   localparam int FRAC_DIGITS = 5;
   localparam int BCD_DIGITS = 10;
   localparam logic [5:0] CONV_STEPS = 6'h20;

   localparam logic [7:0] CH_STAR = 8'h2a;
   localparam logic [7:0] CH_UNDER = 8'h5f;
   localparam logic [7:0] CH_PLUS = 8'h2b;
   localparam logic [7:0] CH_MINUS = 8'h2d;
   localparam logic [7:0] CH_POINT = 8'h2e;
   localparam logic [7:0] CH_ZERO = 8'h30;
   localparam logic [7:0] CH_TARE = 8'h54;
   localparam logic [7:0] CH_CR = 8'h0d;
   localparam logic [7:0] CH_LF = 8'h0a;
   localparam logic [7:0] CH_C = 8'h43;
   localparam logic [7:0] CH_F = 8'h46;

   typedef struct packed {
      logic is_temp;
      logic [31:0] value;
   } meas_t;

   typedef struct packed {
      logic fixed_field_enable;
      logic tare_marker_enable;
      logic separator_enable;
      logic units_suffix_enable;
   } format_t;

   typedef struct packed {
      logic [2:0] len;
      logic [31:0] chars;
   } label_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0000,
      ST_CONV = 4'b0001,
      ST_HEAD = 4'b0011,
      ST_SEP1 = 4'b0010,
      ST_SIGN = 4'b0110,
      ST_INT = 4'b0111,
      ST_POINT = 4'b0101,
      ST_FRAC = 4'b0100,
      ST_PAD = 4'b1100,
      ST_MARK = 4'b1101,
      ST_SEP2 = 4'b1111,
      ST_SUFX = 4'b1110,
      ST_CR = 4'b1010,
      ST_LF = 4'b1011
   } fmt_state_t;
endpackage : press_fmt_pkg

// file: rtl/pressure_units_tare_format.sv
// Contract
// RULE_01 - Pressure unit selector 0..8, default 1; 0 picks user factor.
// RULE_02 - Psi pressure is multiplied by the selected standard unit factor.
// RULE_03 - Unit 0 multiplies by the user factor, default 1.0.
// RULE_04 - Temperature computed in Celsius, converted to Fahrenheit when unit is 1.
// RULE_05 - Tare state: 0 off, 1 requested, 2 active; 0 after reset.
// RULE_06 - First pressure after request is captured; later pressures have it subtracted.
// RULE_07 - Request while active recaptures at next measurement.
// RULE_08 - Writing 0 turns taring off, 1 requests it, only when unlocked.
// RULE_09 - Tare value writable while active, overwritten on capture, 0 after reset.
// RULE_10 - Lockout blocks tare changes from bus and tare line; pending request completes. Bus writes to tare value are not blocked by lockout.
// RULE_11 - Overpressure output high and alert on when pressure reaches setpoint.
// RULE_12 - Setpoint kept in current units, rescaled on unit change, default full scale.
// RULE_13 - Suffix enable appends pressure unit label; unit 0 uses user label.
// RULE_14 - Suffix enable appends C or F to temperature results.
// RULE_15 - Separator enable puts underscores after header and before suffix.
// RULE_16 - Tare marker T follows tared pressure value when marker enabled.
// RULE_17 - Fixed field: asterisk, four address chars, sign, eleven zero-padded chars.
// RULE_18 - User label of four chars 32..127, used with unit 0 and suffix.
// RULE_19 - Formatting options combine freely; fixed field still holds.
// RULE_20 - Each parameter write must directly follow a write-enable write.
// RULE_21 - Tare subtracted after unit conversion.
`timescale 1ns/1ps
`default_nettype none
module pressure_units_tare_format
   import press_fmt_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire meas_t meas,
   input wire logic meas_valid,
   output logic meas_ready,
   input wire logic tare_in,
   output logic overpressure_out,
   output logic alert_out,
   output logic [7:0] tx_char,
   output logic tx_valid,
   input wire logic tx_ready
);
   logic [3:0] pressure_unit_select, idx, field_cnt;
   logic [31:0] user_conversion_factor, user_inverse_factor, tare_value, overpressure_setpoint;
   logic [31:0] user_pressure_label, address_chars, last_pressure, conv_bin;
   logic temperature_unit_select, tare_lockout, write_armed;
   logic [1:0] tare_state;
   format_t fmt;
   logic tare_meta, tare_sync, tare_prev;
   fmt_state_t state;
   logic out_is_temp, out_neg, out_tared;
   logic [39:0] bcd;
   logic [5:0] conv_cnt;

   function automatic logic [31:0] qmul(input logic [31:0] a, input logic [31:0] b);
      logic signed [63:0] p;
      p = $signed(a) * $signed(b);
      return p[FRAC_BITS +: 32];
   endfunction : qmul

   function automatic logic [31:0] unit_factor(input logic [3:0] u, input logic [31:0] user_f);
      unique case (u)
         4'h1: return F_ONE;
         4'h2: return F_HPA;
         4'h3: return F_BAR;
         4'h4: return F_KPA;
         4'h5: return F_MPA;
         4'h6: return F_INHG;
         4'h7: return F_MMHG;
         4'h8: return F_MH2O;
         default: return user_f;
      endcase
   endfunction : unit_factor

   // Inverse factors avoid a divider when rescaling the setpoint
   function automatic logic [31:0] unit_inverse(input logic [3:0] u, input logic [31:0] user_i);
      unique case (u)
         4'h1: return F_ONE;
         4'h2: return 32'($rtoi(ONE_Q / 68.94757 + 0.5));
         4'h3: return 32'($rtoi(ONE_Q / 0.06894757 + 0.5));
         4'h4: return 32'($rtoi(ONE_Q / 6.894757 + 0.5));
         4'h5: return 32'($rtoi(ONE_Q / 0.00689476 + 0.5));
         4'h6: return 32'($rtoi(ONE_Q / 2.036021 + 0.5));
         4'h7: return 32'($rtoi(ONE_Q / 51.71493 + 0.5));
         4'h8: return 32'($rtoi(ONE_Q / 0.7030696 + 0.5));
         default: return user_i;
      endcase
   endfunction : unit_inverse

   // Labels are stored first character in the low byte
   function automatic label_t unit_label(input logic [3:0] u, input logic [31:0] user_l);
      unique case (u)
         4'h1: return '{3'h4, 32'h6169_7370};
         4'h2: return '{3'h3, 32'h0061_5068};
         4'h3: return '{3'h3, 32'h0072_6162};
         4'h4: return '{3'h3, 32'h0061_506b};
         4'h5: return '{3'h3, 32'h0061_504d};
         4'h6: return '{3'h4, 32'h6748_6e69};
         4'h7: return '{3'h4, 32'h6748_6d6d};
         4'h8: return '{3'h4, 32'h4f32_486d};
         default: return '{3'h4, user_l};
      endcase
   endfunction : unit_label

   function automatic logic printable(input logic [31:0] w);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < 4; i++) begin
         if (w[i*8 +: 8] < CHAR_MIN || w[i*8 +: 8] > CHAR_MAX) ok = 1'b0;
      end
      return ok;
   endfunction : printable

   // Bus access decode
   logic wr_acc, rd_acc, wr_param, addr_ok;
   assign pready = 1'b1;
   assign wr_acc = psel && penable && pwrite;
   assign rd_acc = psel && penable && !pwrite;
   assign addr_ok = paddr[1:0] == 2'h0 && paddr <= OFS_LAST_PRESSURE;
   assign wr_param = wr_acc && write_armed && paddr != OFS_WRITE_ENABLE; // RULE_20
   assign pslverr = psel && penable && !addr_ok;

   always_ff @(posedge ref_clk) begin
      if (rst) write_armed <= 1'b0;
      else if (wr_acc) write_armed <= paddr == OFS_WRITE_ENABLE && pwdata == WE_KEY; // RULE_20
   end

   always_ff @(posedge ref_clk) begin
      if (rst) prdata <= '0;
      else if (psel && !penable && !pwrite) begin
         unique case (paddr)
            OFS_WRITE_ENABLE: prdata <= {31'h0, write_armed};
            OFS_PUNIT: prdata <= {28'h0, pressure_unit_select};
            OFS_USER_FACTOR: prdata <= user_conversion_factor;
            OFS_USER_INVERSE: prdata <= user_inverse_factor;
            OFS_TUNIT: prdata <= {31'h0, temperature_unit_select};
            OFS_TARE_STATE: prdata <= {30'h0, tare_state};
            OFS_TARE_VALUE: prdata <= tare_value;
            OFS_TARE_LOCK: prdata <= {31'h0, tare_lockout};
            OFS_SETPOINT: prdata <= overpressure_setpoint;
            OFS_FORMAT: prdata <= {28'h0, fmt};
            OFS_USER_LABEL: prdata <= user_pressure_label;
            OFS_ADDRESS: prdata <= address_chars;
            OFS_STATUS: prdata <= {29'h0, state != ST_IDLE, alert_out, overpressure_out};
            OFS_LAST_PRESSURE: prdata <= last_pressure;
            default: prdata <= '0;
         endcase
      end
   end

   // Unit selection and setpoint rescale
   logic [31:0] cur_factor;
   assign cur_factor = unit_factor(pressure_unit_select, user_conversion_factor);

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pressure_unit_select <= UNIT_PSI; // RULE_01
         user_conversion_factor <= F_ONE; // RULE_03
         user_inverse_factor <= F_ONE;
         temperature_unit_select <= 1'b0; // RULE_04
         overpressure_setpoint <= FULL_SCALE_PSI; // RULE_12
         fmt <= '0;
         user_pressure_label <= USER_LABEL_RESET;
         address_chars <= ADDRESS_RESET;
      end else if (wr_param) begin
         unique case (paddr)
            OFS_PUNIT: if (pwdata <= 32'(UNIT_MAX)) begin // RULE_01
               pressure_unit_select <= pwdata[3:0];
               overpressure_setpoint <= qmul(qmul(overpressure_setpoint, // RULE_12
                  unit_inverse(pressure_unit_select, user_inverse_factor)),
                  unit_factor(pwdata[3:0], user_conversion_factor));
            end
            OFS_USER_FACTOR: user_conversion_factor <= pwdata;
            OFS_USER_INVERSE: user_inverse_factor <= pwdata;
            OFS_TUNIT: temperature_unit_select <= pwdata[0];
            OFS_SETPOINT: overpressure_setpoint <= pwdata;
            OFS_FORMAT: fmt <= pwdata[3:0]; // RULE_19
            OFS_USER_LABEL: if (printable(pwdata)) user_pressure_label <= pwdata; // RULE_18
            OFS_ADDRESS: address_chars <= pwdata;
            default: ;
         endcase
      end
   end

   // Tare line passes two flops before the edge detector
   always_ff @(posedge ref_clk) begin
      if (rst) {tare_meta, tare_sync, tare_prev} <= 3'h0;
      else {tare_meta, tare_sync, tare_prev} <= {tare_in, tare_meta, tare_sync};
   end

   // Measurement path
   logic take;
   logic [31:0] conv_p, net_p, temp_out, result;
   logic capture;
   assign meas_ready = state == ST_IDLE && !tx_valid; // Low until the LF is taken
   assign take = meas_valid && meas_ready;
   assign conv_p = qmul(meas.value, cur_factor); // RULE_02 RULE_03
   assign capture = take && !meas.is_temp && tare_state == TARE_REQ; // RULE_06 RULE_07
   assign net_p = capture ? '0 : (tare_state == TARE_ACTIVE ? conv_p - tare_value : conv_p); // RULE_21
   assign temp_out = temperature_unit_select ? qmul(meas.value, F_FAHR_SCALE) + FAHR_OFFSET
                                             : meas.value; // RULE_04
   assign result = meas.is_temp ? temp_out : net_p;

   always_ff @(posedge ref_clk) begin
      if (rst) tare_state <= TARE_OFF; // RULE_05
      else if (wr_param && paddr == OFS_TARE_STATE && !tare_lockout && pwdata < 32'(TARE_ACTIVE))
         tare_state <= pwdata[1:0]; // RULE_08 RULE_10
      else if (tare_sync && !tare_prev && !tare_lockout) tare_state <= TARE_REQ; // RULE_10
      else if (capture) tare_state <= TARE_ACTIVE; // RULE_06 RULE_10
   end

   always_ff @(posedge ref_clk) begin
      if (rst) tare_value <= '0; // RULE_09
      else if (capture) tare_value <= conv_p; // RULE_09
      else if (wr_param && paddr == OFS_TARE_VALUE && tare_state == TARE_ACTIVE) tare_value <= pwdata; // RULE_09
   end

   always_ff @(posedge ref_clk) begin
      if (rst) tare_lockout <= 1'b0; // RULE_10
      else if (wr_param && paddr == OFS_TARE_LOCK) tare_lockout <= pwdata[0];
   end

   // Alarm compares the unit-converted, tared pressure
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         overpressure_out <= 1'b0;
         alert_out <= 1'b0;
         last_pressure <= '0;
      end else if (take && !meas.is_temp) begin
         overpressure_out <= $signed(net_p) >= $signed(overpressure_setpoint); // RULE_11
         alert_out <= $signed(net_p) >= $signed(overpressure_setpoint); // RULE_11
         last_pressure <= net_p;
      end
   end

   // Binary to BCD, one bit per cycle
   logic [39:0] bcd_adj;
   logic [47:0] scaled;
   logic [31:0] mag;
   assign mag = result[31] ? 32'(-result) : result;
   assign scaled = 48'(mag) * 48'(DEC_SCALE);
   for (genvar g = 0; g < BCD_DIGITS; g++) begin : g_dabble
      assign bcd_adj[g*4 +: 4] = bcd[g*4 +: 4] >= 4'h5 ? bcd[g*4 +: 4] + 4'h3 : bcd[g*4 +: 4];
   end

   // Character sequencer
   label_t lab;
   logic [3:0] lead;
   logic emit, slot;
   logic [7:0] ch;
   fmt_state_t next_state;
   logic [3:0] next_idx;
   assign lab = out_is_temp ? '{3'h1, {24'h0, temperature_unit_select ? CH_F : CH_C}} // RULE_14
                            : unit_label(pressure_unit_select, user_pressure_label); // RULE_13 RULE_18
   assign slot = !tx_valid || tx_ready;

   always_comb begin
      lead = 4'(FRAC_DIGITS);
      for (int i = BCD_DIGITS - 1; i > FRAC_DIGITS; i--) begin
         if (bcd[i*4 +: 4] != 4'h0 && lead < 4'(i)) lead = 4'(i);
      end
   end

   always_comb begin
      emit = 1'b0;
      ch = CH_ZERO;
      next_state = state;
      next_idx = idx;
      unique case (state)
         ST_IDLE, ST_CONV: ;
         ST_HEAD: begin
            emit = 1'b1;
            ch = idx == 4'h0 ? CH_STAR : address_chars[(idx - 4'h1)*8 +: 8];
            next_idx = idx + 4'h1;
            if (idx == 4'h4) next_state = ST_SEP1;
         end
         ST_SEP1: begin
            emit = fmt.separator_enable; // RULE_15
            ch = CH_UNDER;
            next_state = ST_SIGN;
         end
         ST_SIGN: begin
            emit = fmt.fixed_field_enable || out_neg; // RULE_17
            ch = out_neg ? CH_MINUS : CH_PLUS;
            next_state = ST_INT;
            next_idx = lead;
         end
         ST_INT: begin
            emit = 1'b1;
            ch = CH_ZERO | {4'h0, bcd[idx*4 +: 4]};
            next_idx = idx - 4'h1;
            if (idx == 4'(FRAC_DIGITS)) next_state = ST_POINT;
         end
         ST_POINT: begin
            emit = 1'b1;
            ch = CH_POINT;
            next_state = ST_FRAC;
         end
         ST_FRAC: begin
            emit = 1'b1;
            ch = CH_ZERO | {4'h0, bcd[idx*4 +: 4]};
            next_idx = idx - 4'h1;
            if (idx == 4'h0) next_state = ST_PAD;
         end
         ST_PAD: begin
            emit = fmt.fixed_field_enable && field_cnt < 4'(FIELD_CHARS); // RULE_17 RULE_19
            if (!emit) next_state = ST_MARK;
         end
         ST_MARK: begin
            emit = fmt.tare_marker_enable && out_tared && !out_is_temp; // RULE_16
            ch = CH_TARE;
            next_state = ST_SEP2;
         end
         ST_SEP2: begin
            emit = fmt.separator_enable && fmt.units_suffix_enable; // RULE_15
            ch = CH_UNDER;
            next_state = ST_SUFX;
            next_idx = 4'h0;
         end
         ST_SUFX: begin
            emit = fmt.units_suffix_enable && idx < {1'b0, lab.len}; // RULE_13 RULE_14
            ch = lab.chars[idx[1:0]*8 +: 8];
            next_idx = idx + 4'h1;
            if (!emit) next_state = ST_CR;
         end
         ST_CR: begin
            emit = 1'b1;
            ch = CH_CR;
            next_state = ST_LF;
         end
         ST_LF: begin
            emit = 1'b1;
            ch = CH_LF;
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state <= ST_IDLE;
         idx <= '0;
         conv_cnt <= '0;
         conv_bin <= '0;
         bcd <= '0;
         out_is_temp <= 1'b0;
         out_neg <= 1'b0;
         out_tared <= 1'b0;
      end else if (state == ST_IDLE) begin
         if (take) begin
            state <= ST_CONV;
            conv_bin <= scaled[47:16];
            bcd <= '0;
            conv_cnt <= '0;
            out_is_temp <= meas.is_temp;
            out_neg <= result[31];
            out_tared <= capture || tare_state == TARE_ACTIVE; // RULE_16
         end
      end else if (state == ST_CONV) begin
         bcd <= {bcd_adj[38:0], conv_bin[31]};
         conv_bin <= {conv_bin[30:0], 1'b0};
         conv_cnt <= conv_cnt + 6'h1;
         idx <= '0;
         if (conv_cnt == CONV_STEPS - 6'h1) state <= ST_HEAD;
      end else if (!emit || slot) begin
         state <= next_state;
         idx <= next_idx;
      end
   end

   // Counts value characters for the fixed field
   always_ff @(posedge ref_clk) begin
      if (rst || state == ST_CONV) field_cnt <= '0;
      else if (emit && slot && (state == ST_INT || state == ST_POINT || state == ST_FRAC || state == ST_PAD))
         field_cnt <= field_cnt + 4'h1; // RULE_17
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         tx_valid <= 1'b0;
         tx_char <= '0;
      end else if (emit && slot) begin
         tx_valid <= 1'b1;
         tx_char <= ch;
      end else if (tx_ready) begin
         tx_valid <= 1'b0;
      end
   end
endmodule : pressure_units_tare_format
`default_nettype wire

// file: test/host_sink.sv
`timescale 1ns/1ps
`default_nettype none
module host_sink
   import press_fmt_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic slow,
   input wire logic [7:0] tx_char,
   input wire logic tx_valid,
   output logic tx_ready
);
   string cur;
   string last;
   int lines;
   // Slow mode stalls every other cycle so held chars are exercised
   always @(posedge ref_clk) begin
      if (rst) begin
         tx_ready <= 1'b0;
         lines <= 0;
         cur = "";
      end else begin
         tx_ready <= slow ? ~tx_ready : 1'b1;
         if (tx_valid && tx_ready && tx_char == CH_LF) begin
            last <= cur;
            cur = "";
            lines <= lines + 1;
         end else if (tx_valid && tx_ready && tx_char != CH_CR) begin
            cur = {cur, string'(tx_char)};
         end
      end
   end
endmodule : host_sink
`default_nettype wire

// file: test/press_fmt_chk.sv
`timescale 1ns/1ps
`default_nettype none
module press_fmt_chk
   import press_fmt_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic pready,
   input wire meas_t meas,
   input wire logic meas_valid,
   input wire logic meas_ready,
   input wire logic overpressure_out,
   input wire logic alert_out,
   input wire logic [7:0] tx_char,
   input wire logic tx_valid,
   input wire logic tx_ready
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   wire logic take = meas_valid && meas_ready;
   sequence s_cr_acc;
      tx_valid && tx_ready && tx_char == CH_CR;
   endsequence
   sequence s_lf_acc;
      tx_valid && tx_ready && tx_char == CH_LF;
   endsequence
   sequence s_lf_up;
      tx_valid && tx_char == CH_LF;
   endsequence
   AST_CR_LF: assert property (s_cr_acc |=> s_lf_up) else $error("no LF after CR");
   AST_LF_IDLE: assert property (s_lf_acc |=> !tx_valid && meas_ready) else $error("not idle after LF");
   AST_QUIET: assert property (take |=> !tx_valid [*8]) else $error("char during conversion");
   AST_STAR: assert property (take |-> ##[1:60] (tx_valid && tx_char == CH_STAR)) else $error("no star");
   AST_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_char)) else $error("char dropped");
   AST_BUSY: assert property (tx_valid |-> !meas_ready) else $error("ready while sending");
   AST_ALERT_EQ: assert property (overpressure_out == alert_out) else $error("alert differs");
   AST_ALARM_SRC: assert property ($changed(overpressure_out) |-> $past(take && !meas.is_temp))
      else $error("alarm moved without pressure");
   AST_PREADY: assert property (psel |-> pready) else $error("pready low");
   AST_RESET: assert property (disable iff (1'b0) rst |=> !tx_valid && !overpressure_out)
      else $error("reset not cleared");
endmodule : press_fmt_chk
bind pressure_units_tare_format press_fmt_chk chk_inst (.*);
`default_nettype wire

// file: test/pressure_units_tare_format_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pressure_units_tare_format_tb
   import press_fmt_pkg::*;
   ;
   typedef struct {logic [3:0] u; logic [3:0] f; logic t; logic tu; logic [31:0] v; string s;} row_t;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, meas_valid = 1'b0, tare_in = 1'b0, slow = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, serr, meas_ready, overpressure_out, alert_out, tx_valid, tx_ready;
   logic [7:0] tx_char;
   meas_t meas = '0;
   int err_total = 0, comparisons = 0, cyc = 0;
   row_t rows[16] = '{
      '{4'h1, 4'h0, 1'b0, 1'b0, 32'h000e8000, "*000114.50000"},
      '{4'h1, 4'h1, 1'b0, 1'b0, 32'h000e8000, "*000114.50000psia"},
      '{4'h1, 4'h3, 1'b0, 1'b0, 32'h000e8000, "*0001_14.50000_psia"},
      '{4'h1, 4'h8, 1'b0, 1'b0, 32'h000e8000, "*0001+14.50000000"},
      '{4'h1, 4'hf, 1'b0, 1'b0, 32'hfffdc000, "*0001_-2.250000000_psia"},
      '{4'h1, 4'h0, 1'b0, 1'b0, 32'hfffdc000, "*0001-2.25000"},
      '{4'h0, 4'h1, 1'b0, 1'b0, 32'h00014000, "*00012.50000user"},
      '{4'h1, 4'h1, 1'b1, 1'b0, 32'h0, "*00010.00000C"},
      '{4'h1, 4'h1, 1'b1, 1'b1, 32'h0, "*000132.00000F"},
      '{4'h2, 4'h1, 1'b0, 1'b0, 32'h0, "*00010.00000hPa"},
      '{4'h3, 4'h1, 1'b0, 1'b0, 32'h0, "*00010.00000bar"},
      '{4'h4, 4'h1, 1'b0, 1'b0, 32'h0, "*00010.00000kPa"},
      '{4'h5, 4'h1, 1'b0, 1'b0, 32'h0, "*00010.00000MPa"},
      '{4'h6, 4'h1, 1'b0, 1'b0, 32'h0, "*00010.00000inHg"},
      '{4'h7, 4'h1, 1'b0, 1'b0, 32'h0, "*00010.00000mmHg"},
      '{4'h8, 4'h1, 1'b0, 1'b0, 32'h0, "*00010.00000mH2O"}};
   pressure_units_tare_format pressure_units_tare_format_inst (.*);
   host_sink host_sink_inst (.*);
   initial forever #12.5 ref_clk = ~ref_clk;
   task finish_test;
      $display("comparisons %0d err_total %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : finish_test
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         finish_test();
      end
   end
   task cmp_v(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (e !== g) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : cmp_v
   task cmp_s(input string n, input string e, input string g);
      comparisons++;
      if (e != g) begin
         err_total++;
         $display("[ERR] %s expected %s seen %s", n, e, g);
      end
   endtask : cmp_s
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rd = prdata;
      serr = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb
   task wreg(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, OFS_WRITE_ENABLE, WE_KEY);
      apb(1'b1, a, d);
   endtask : wreg
   task rchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      cmp_v($sformatf("reg %h", a), e, rd);
   endtask : rchk
   task send(input logic t, input logic [31:0] v);
      int n;
      n = host_sink_inst.lines;
      while (meas_ready !== 1'b1) @(posedge ref_clk);
      @(posedge ref_clk);
      meas <= '{is_temp: t, value: v}; meas_valid <= 1'b1;
      @(posedge ref_clk);
      meas_valid <= 1'b0;
      while (host_sink_inst.lines == n) @(negedge ref_clk);
   endtask : send
   task pulse;
      tare_in <= 1'b1;
      repeat (4) @(posedge ref_clk);
      tare_in <= 1'b0;
      repeat (4) @(posedge ref_clk);
   endtask : pulse
   initial begin
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      rchk(OFS_PUNIT, 32'h1);
      rchk(OFS_USER_FACTOR, F_ONE);
      rchk(OFS_TUNIT, 32'h0);
      rchk(OFS_TARE_STATE, 32'h0);
      rchk(OFS_TARE_VALUE, 32'h0);
      rchk(OFS_TARE_LOCK, 32'h0);
      rchk(OFS_SETPOINT, FULL_SCALE_PSI);
      rchk(OFS_FORMAT, 32'h0);
      wreg(OFS_USER_FACTOR, 32'h00800000);
      foreach (rows[i]) begin
         wreg(OFS_PUNIT, {28'h0, rows[i].u});
         wreg(OFS_FORMAT, {28'h0, rows[i].f});
         wreg(OFS_TUNIT, {31'h0, rows[i].tu});
         slow <= (i % 2) == 1;
         send(rows[i].t, rows[i].v);
         cmp_s("line", rows[i].s, host_sink_inst.last);
      end
      apb(1'b1, OFS_PUNIT, 32'h2);
      rchk(OFS_PUNIT, 32'h8);
      wreg(OFS_PUNIT, 32'h9);
      rchk(OFS_PUNIT, 32'h8);
      apb(1'b0, 8'h38, 32'h0);
      cmp_v("slverr", 32'h1, {31'h0, serr});
      wreg(OFS_PUNIT, 32'h1);
      wreg(OFS_FORMAT, 32'h4);
      wreg(OFS_SETPOINT, 32'h000e8000);
      send(1'b0, 32'h000e8000);
      cmp_v("alarm", 32'h1, {31'h0, overpressure_out});
      send(1'b0, 32'h000e7fff);
      cmp_v("alarm", 32'h0, {31'h0, overpressure_out});
      wreg(OFS_TARE_STATE, 32'h1);
      send(1'b0, 32'h000e8000);
      cmp_s("line", "*00010.00000T", host_sink_inst.last);
      rchk(OFS_TARE_STATE, 32'h2);
      rchk(OFS_TARE_VALUE, 32'h000e8000);
      send(1'b0, 32'h00100000);
      cmp_s("line", "*00011.50000T", host_sink_inst.last);
      wreg(OFS_TARE_VALUE, 32'h00010000);
      send(1'b0, 32'h00100000);
      cmp_s("line", "*000115.00000T", host_sink_inst.last);
      wreg(OFS_TARE_STATE, 32'h1);
      wreg(OFS_TARE_LOCK, 32'h1);
      send(1'b0, 32'h00110000);
      rchk(OFS_TARE_VALUE, 32'h00110000);
      wreg(OFS_TARE_STATE, 32'h0);
      pulse();
      rchk(OFS_TARE_STATE, 32'h2);
      wreg(OFS_TARE_LOCK, 32'h0);
      wreg(OFS_TARE_STATE, 32'h0);
      send(1'b0, 32'h00110000);
      cmp_s("line", "*000117.00000", host_sink_inst.last);
      pulse();
      rchk(OFS_TARE_STATE, 32'h1);
      wreg(OFS_SETPOINT, 32'h000e8000);
      wreg(OFS_PUNIT, 32'h0);
      rchk(OFS_SETPOINT, 32'h001d0000);
      finish_test();
   end
endmodule : pressure_units_tare_format_tb
`default_nettype wire
